//--- hdl/lrf_pkg.sv
// shared constants, command patterns and helpers for the refresh scheduling link
package lrf_pkg;
	// ************************************************************
	// geometry and clock
	// ************************************************************
	localparam int NUM_BANKS     = 8;
	localparam int BANK_W        = 3;
	localparam int CA_W          = 5;
	localparam int CLK_PERIOD_PS = 5000;
	localparam int CNT_W         = 16;
	localparam int CRED_W        = 5;
	localparam int CREDIT_MAX    = 8;

	// ************************************************************
	// timing in ns (plain defaults) and derived cycle counts
	// ************************************************************
	localparam int T_RFCAB_NS = 210;
	localparam int T_RFCPB_NS = 90;
	localparam int T_RRD_NS   = 10;
	localparam int T_RP_NS    = 18;
	localparam int T_XSR_NS   = 220;
	localparam int T_REFI_NS  = 3900;

	// least times round up, never below one cycle
	function automatic int ns_up(int ns);
		int c;
		c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	// the average interval is a longest time, so it rounds down
	function automatic int ns_down(int ns);
		int c;
		c = (ns * 1000) / CLK_PERIOD_PS;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int RFCAB_CYC = ns_up(T_RFCAB_NS);
	localparam int RFCPB_CYC = ns_up(T_RFCPB_NS);
	localparam int RRD_CYC   = ns_up(T_RRD_NS);
	localparam int RP_CYC    = ns_up(T_RP_NS);
	localparam int XSR_CYC   = ns_up(T_XSR_NS);
	localparam int REFI_CYC  = ns_down(T_REFI_NS);

	// ************************************************************
	// command patterns on ca[4:0] and the bits each one compares
	// ************************************************************
	localparam logic [CA_W-1:0] CA_REF_PB = 5'h04;
	localparam logic [CA_W-1:0] CA_REF_AB = 5'h0c;
	localparam logic [CA_W-1:0] CA_ACT    = 5'h02;
	localparam logic [CA_W-1:0] CA_PRE    = 5'h0b;
	localparam logic [CA_W-1:0] CA_PRE_AB = 5'h1b;
	localparam logic [CA_W-1:0] CA_RST    = 5'h00;
	localparam logic [CA_W-1:0] CA_NOP    = 5'h07;
	localparam logic [CA_W-1:0] M_REF     = 5'h07;
	localparam logic [CA_W-1:0] M_ACT     = 5'h03;
	localparam logic [CA_W-1:0] M_PRE     = 5'h0f;
	localparam int              CA_PB_AB  = 3;
	localparam int              CA_PRE_ALL = 4;

	function automatic logic ca_match(logic [CA_W-1:0] ca, logic [CA_W-1:0] pat,
		logic [CA_W-1:0] msk);
		return ((ca ^ pat) & msk) == '0;
	endfunction
endpackage

//--- hdl/lrf_link_if.sv
// command/address link between the memory controller and the device
`timescale 1ns/1ps
interface lrf_link_if;
	import lrf_pkg::*;
	logic              cs_n;
	logic              cke;
	logic [CA_W-1:0]   ca;
	logic [BANK_W-1:0] ba;

	modport ctrl (output cs_n, output cke, output ca, output ba);
	modport dev  (input cs_n, input cke, input ca, input ba);
endinterface

//--- hdl/lrf_timer.sv
// down counter that reports busy while a minimum separation is running
`timescale 1ns/1ps
module lrf_timer
	import lrf_pkg::*;
#(
	parameter int W = CNT_W
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              busy
);
	logic [W-1:0] cnt_r;

	// a load restarts the wait even if one is running
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cnt_r <= '0;
		end else if (load) begin
			cnt_r <= count;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign busy = (cnt_r != '0);
endmodule

//--- hdl/lrf_dev.sv
// device end: refresh decode, bank pointer and per-bank refresh occupancy
`timescale 1ns/1ps
module lrf_dev
	import lrf_pkg::*;
#(
	parameter int RFCAB = RFCAB_CYC,
	parameter int RFCPB = RFCPB_CYC
) (
	input  wire logic                 core_clk,
	input  wire logic                 rst,
	lrf_link_if.dev                   link,
	output logic [BANK_W-1:0]         bank_ptr,
	output logic [NUM_BANKS-1:0]      bank_busy,
	output logic [NUM_BANKS-1:0]      bank_open,
	output logic                      in_sref,
	output logic                      ref_pb_seen,
	output logic                      ref_ab_seen,
	output logic                      access_err
);
	// ************************************************************
	// command decode
	// ************************************************************
	logic                 cke_prev_r;
	logic                 sel;
	logic                 is_ref;
	logic                 ref_pb;
	logic                 ref_ab;
	logic                 sr_entry;
	logic                 sr_exit;
	logic                 is_act;
	logic                 is_pre;
	logic                 is_rst;
	logic [NUM_BANKS-1:0] pb_load;
	logic                 ab_busy;
	logic [BANK_W-1:0]    bank_ptr_r;
	logic [NUM_BANKS-1:0] bank_open_r;
	logic                 in_sref_r;

	// the pattern cs low, ca0 low, ca1 low, ca2 high is a refresh
	assign sel      = !link.cs_n && !in_sref_r;
	assign is_ref   = sel && ca_match(link.ca, CA_REF_PB, M_REF);
	assign ref_pb   = is_ref && link.cke && cke_prev_r && !link.ca[CA_PB_AB];
	assign ref_ab   = is_ref && link.cke && cke_prev_r && link.ca[CA_PB_AB];
	assign sr_entry = is_ref && !link.cke && cke_prev_r;
	assign sr_exit  = in_sref_r && link.cke;
	assign is_act   = sel && link.cke && ca_match(link.ca, CA_ACT, M_ACT);
	assign is_pre   = sel && link.cke && ca_match(link.ca, CA_PRE, M_PRE);
	assign is_rst   = sel && link.cke && ca_match(link.ca, CA_RST, M_PRE);

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cke_prev_r <= 1'b1;
		end else begin
			cke_prev_r <= link.cke;
		end
	end

	// ************************************************************
	// per-bank pointer
	// ************************************************************
	// every resync source wins over the step
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bank_ptr_r <= '0;
		end else if (is_rst || sr_exit) begin
			bank_ptr_r <= '0;
		end else if (ref_ab) begin
			bank_ptr_r <= '0;
		end else if (ref_pb) begin
			bank_ptr_r <= bank_ptr_r + 1'b1;
		end
	end

	// ************************************************************
	// self refresh state
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			in_sref_r <= 1'b0;
		end else if (sr_entry) begin
			in_sref_r <= 1'b1;
		end else if (sr_exit) begin
			in_sref_r <= 1'b0;
		end
	end

	// ************************************************************
	// refresh occupancy: one timer per bank plus one for all banks
	// ************************************************************
	always_comb begin
		pb_load = '0;
		pb_load[bank_ptr_r] = ref_pb;
	end

	genvar gb;
	generate
		for (gb = 0; gb < NUM_BANKS; gb++) begin : g_bank
			lrf_timer #(.W(CNT_W)) u_pb (
				.core_clk (core_clk),
				.rst      (rst),
				.load     (pb_load[gb]),
				.count    (CNT_W'(RFCPB - 1)), // command cycle counts as the first
				.busy     (bank_busy[gb])
			);
		end
	endgenerate

	lrf_timer #(.W(CNT_W)) u_ab (
		.core_clk (core_clk),
		.rst      (rst),
		.load     (ref_ab),
		.count    (CNT_W'(RFCAB - 1)), // next command legal exactly RFCAB later
		.busy     (ab_busy)
	);

	// ************************************************************
	// bank open tracking
	// ************************************************************
	// refresh closes banks so they end idle; a per-bank refresh touches only its target, an all-bank refresh clears all
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			bank_open_r <= '0;
		end else if (ref_ab || is_rst) begin
			bank_open_r <= '0;
		end else if (ref_pb) begin
			bank_open_r[bank_ptr_r] <= 1'b0;
		end else if (is_pre && link.ca[CA_PRE_ALL]) begin
			bank_open_r <= '0;
		end else if (is_pre) begin
			bank_open_r[link.ba] <= 1'b0;
		end else if (is_act && !bank_busy[link.ba] && !ab_busy) begin
			bank_open_r[link.ba] <= 1'b1;
		end
	end

	// flags an activate to a refreshing bank; other banks stay usable
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			access_err  <= 1'b0;
			ref_pb_seen <= 1'b0;
			ref_ab_seen <= 1'b0;
		end else begin
			access_err  <= is_act && (bank_busy[link.ba] || ab_busy);
			ref_pb_seen <= ref_pb;
			ref_ab_seen <= ref_ab;
		end
	end

	assign bank_ptr  = bank_ptr_r;
	assign bank_open = bank_open_r;
	assign in_sref   = in_sref_r;
endmodule

//--- hdl/lrf_ctrl.sv
// controller end: refresh scheduler with credit, shadow pointer and separations
// Overview of operation
// - refresh is cs low, ca 0 0 1
// - ca3 low per-bank, high all-bank
// - per-bank target steps 0..7 round robin
// - device pointer clears on reset, self-refresh exit
// - all-bank refresh also clears the pointer
// - controller tracks target bank, ensures it idle
// - per-bank waits ab, pb, precharge, activate spacing
// - refreshing bank unavailable, others stay usable
// - per-bank refresh leaves its bank idle
// - after per-bank: pb cycle, activate spacing waits
// - all banks idle before all-bank refresh
// - all-bank waits ab, pb and precharge times
// - all-bank ends idle; wait its cycle
// - no all-bank refresh with any bank open
// - at most eight refreshes postponed
// - at most eight refreshes pulled in
// - per-bank credit counts in units of eight
// - only nops during refresh cycle, except others
// - minimum refresh count per rolling window
// - eight per-bank refreshes equal one all-bank
// - credit frozen during self refresh
// - extra refresh needed before re-entering self refresh
`timescale 1ns/1ps
module lrf_ctrl
	import lrf_pkg::*;
#(
	parameter int RFCAB = RFCAB_CYC,
	parameter int RFCPB = RFCPB_CYC,
	parameter int RRD   = RRD_CYC,
	parameter int RP    = RP_CYC,
	parameter int XSR   = XSR_CYC,
	parameter int REFI  = REFI_CYC
) (
	input  wire logic              core_clk,
	input  wire logic              rst,
	lrf_link_if.ctrl               link,
	input  wire logic              per_bank_mode,
	input  wire logic              act_req,
	input  wire logic [BANK_W-1:0] act_bank,
	output logic                   act_ready,
	input  wire logic              pre_req,
	input  wire logic              pre_all,
	input  wire logic [BANK_W-1:0] pre_bank,
	output logic                   pre_ready,
	input  wire logic              rst_req,
	output logic                   rst_ready,
	input  wire logic              sr_enter_req,
	output logic                   sr_enter_ready,
	input  wire logic              sr_exit_req,
	output logic                   in_sref,
	output logic signed [CRED_W-1:0] credit,
	output logic [BANK_W-1:0]      shadow_ptr,
	output logic                   ref_issued
);
	typedef enum logic [1:0] {
		ST_RUN  = 2'b00,
		ST_SREF = 2'b01,
		ST_XSR  = 2'b10
	} lrf_state_e;

	localparam logic signed [CRED_W-1:0] CRED_HI = CRED_W'(CREDIT_MAX);
	localparam logic signed [CRED_W-1:0] CRED_LO = -CRED_W'(CREDIT_MAX);
	// a one-bit signed literal would read as minus one, so the step is full width
	localparam logic signed [CRED_W-1:0] CRED_STEP = CRED_W'(1);

	lrf_state_e                 state_r;
	lrf_state_e                 state_nxt;
	logic signed [CRED_W-1:0]   credit_r;
	logic [BANK_W-1:0]          ptr_r;
	logic [BANK_W-1:0]          pb_bank_r;
	logic [NUM_BANKS-1:0]       open_r;
	logic                       extra_ref_r;
	logic [CNT_W-1:0]           refi_cnt_r;
	logic                       tick;
	logic                       t_ab;
	logic                       t_pb;
	logic                       t_rrd;
	logic                       t_rp;
	logic                       t_xsr;
	logic                       ab_ok;
	logic                       pb_ok;
	logic                       urgent;
	logic                       want_ref;
	logic                       do_ab;
	logic                       do_pb;
	logic                       do_pre_all;
	logic                       do_act;
	logic                       do_pre;
	logic                       do_rst;
	logic                       do_sre;
	logic                       do_srx;
	logic                       cred_up;

	// ************************************************************
	// separation timers
	// ************************************************************
	lrf_timer #(.W(CNT_W)) u_ab (.core_clk(core_clk), .rst(rst), .load(do_ab),
		.count(CNT_W'(RFCAB - 1)), .busy(t_ab));
	lrf_timer #(.W(CNT_W)) u_pb (.core_clk(core_clk), .rst(rst), .load(do_pb),
		.count(CNT_W'(RFCPB - 1)), .busy(t_pb));
	lrf_timer #(.W(CNT_W)) u_rrd (.core_clk(core_clk), .rst(rst), .load(do_act || do_pb),
		.count(CNT_W'(RRD - 1)), .busy(t_rrd));
	lrf_timer #(.W(CNT_W)) u_rp (.core_clk(core_clk), .rst(rst),
		.load(do_pre || do_pre_all), .count(CNT_W'(RP - 1)), .busy(t_rp));
	lrf_timer #(.W(CNT_W)) u_xsr (.core_clk(core_clk), .rst(rst), .load(do_srx),
		.count(CNT_W'(XSR - 1)), .busy(t_xsr));

	// ************************************************************
	// refresh interval tick
	// ************************************************************
	// one tick per average interval; the window minimum follows from it
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			refi_cnt_r <= '0;
		end else if (refi_cnt_r == CNT_W'(REFI - 1)) begin
			refi_cnt_r <= '0;
		end else begin
			refi_cnt_r <= refi_cnt_r + 1'b1;
		end
	end
	assign tick = (refi_cnt_r == CNT_W'(REFI - 1)) && (state_r != ST_SREF);

	// ************************************************************
	// issue decision, one command per cycle
	// ************************************************************
	assign urgent   = (credit_r <= CRED_LO);
	assign want_ref = (credit_r < 0) || (!act_req && !pre_req && credit_r < CRED_HI);
	assign ab_ok    = !t_ab && !t_pb && !t_rp && (open_r == '0);
	assign pb_ok    = !t_ab && !t_pb && !t_rp && !t_rrd && !open_r[ptr_r];
	assign cred_up  = do_ab || (do_pb && ptr_r == BANK_W'(NUM_BANKS - 1));

	// a reset command goes first, then refresh once it is wanted; user traffic waits behind it
	always_comb begin
		do_ab      = 1'b0;
		do_pb      = 1'b0;
		do_pre_all = 1'b0;
		do_act     = 1'b0;
		do_pre     = 1'b0;
		do_rst     = 1'b0;
		do_sre     = 1'b0;
		do_srx     = 1'b0;
		state_nxt  = state_r;
		case (state_r)
			ST_RUN: begin
				if (rst_req && !t_ab && !t_pb) begin
					do_rst = 1'b1;
				end else if (want_ref && !per_bank_mode && ab_ok) begin
					do_ab = 1'b1;
				end else if (want_ref && per_bank_mode && pb_ok) begin
					do_pb = 1'b1;
				end else if (urgent && open_r != '0 && !t_ab && !t_pb && !t_rp) begin
					do_pre_all = 1'b1;
				end else if (sr_enter_req && !extra_ref_r && ab_ok) begin
					do_sre    = 1'b1;
					state_nxt = ST_SREF;
				end else if (pre_req && !t_ab
					&& !(t_pb && (pre_all || pre_bank == pb_bank_r))) begin
					do_pre = 1'b1;
				end else if (act_req && !urgent && !t_ab && !t_rrd && !open_r[act_bank]
					&& !(t_pb && act_bank == pb_bank_r)) begin
					do_act = 1'b1;
				end
			end
			ST_SREF: begin
				if (sr_exit_req) begin
					do_srx    = 1'b1;
					state_nxt = ST_XSR;
				end
			end
			ST_XSR: begin
				if (!t_xsr) begin
					state_nxt = ST_RUN;
				end
			end
			default: state_nxt = ST_RUN;
		endcase
	end

	assign act_ready      = do_act;
	assign pre_ready      = do_pre;
	assign rst_ready      = do_rst;
	assign sr_enter_ready = do_sre;

	// ************************************************************
	// link drive
	// ************************************************************
	// everything leaves on flops; idle cycles carry a nop
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			link.cs_n <= 1'b1;
			link.cke  <= 1'b1;
			link.ca   <= CA_NOP;
			link.ba   <= '0;
		end else begin
			link.cs_n <= !(do_ab || do_pb || do_pre_all || do_act || do_pre
				|| do_rst || do_sre);
			link.ba   <= do_act ? act_bank : pre_bank;
			if (do_ab) begin
				link.ca <= CA_REF_AB;
			end else if (do_pb || do_sre) begin
				link.ca <= CA_REF_PB;
			end else if (do_pre_all || (do_pre && pre_all)) begin
				link.ca <= CA_PRE_AB;
			end else if (do_pre) begin
				link.ca <= CA_PRE;
			end else if (do_act) begin
				link.ca <= CA_ACT;
			end else if (do_rst) begin
				link.ca <= CA_RST;
			end else begin
				link.ca <= CA_NOP;
			end
			if (do_sre) begin
				link.cke <= 1'b0;
			end else if (do_srx) begin
				link.cke <= 1'b1;
			end
		end
	end

	// ************************************************************
	// scheduler state
	// ************************************************************
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= ST_RUN;
		end else begin
			state_r <= state_nxt;
		end
	end

	// shadow pointer mirrors the device's bank counter
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ptr_r     <= '0;
			pb_bank_r <= '0;
		end else if (do_ab || do_rst || do_srx) begin
			ptr_r <= '0;
		end else if (do_pb) begin
			ptr_r     <= ptr_r + 1'b1;
			pb_bank_r <= ptr_r;
		end
	end

	// shadow of open banks; refresh leaves its targets idle
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			open_r <= '0;
		end else if (do_pre_all || do_rst || (do_pre && pre_all)) begin
			open_r <= '0;
		end else if (do_pre) begin
			open_r[pre_bank] <= 1'b0;
		end else if (do_act) begin
			open_r[act_bank] <= 1'b1;
		end
	end

	// credit: +1 per all-bank refresh or per eighth per-bank refresh, -1 per interval due; sat keeps it in range
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			credit_r <= '0;
		end else if (cred_up && !tick) begin
			credit_r <= (credit_r < CRED_HI) ? credit_r + CRED_STEP : credit_r;
		end else if (tick && !cred_up) begin
			credit_r <= (credit_r > CRED_LO) ? credit_r - CRED_STEP : credit_r;
		end
	end

	// a refresh lost at exit must be made up before the next entry
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			extra_ref_r <= 1'b0;
		end else if (do_srx) begin
			extra_ref_r <= 1'b1;
		end else if (cred_up) begin
			extra_ref_r <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			ref_issued <= 1'b0;
		end else begin
			ref_issued <= do_ab || do_pb;
		end
	end

	assign in_sref    = (state_r == ST_SREF);
	assign credit     = credit_r;
	assign shadow_ptr = ptr_r;
endmodule

//--- verification/lrf_link_assertions.sv
// link rule checker for the refresh scheduling link
`timescale 1ns/1ps
module lrf_link_assertions
	import lrf_pkg::*;
#(
	parameter int RFCAB = RFCAB_CYC,
	parameter int RFCPB = RFCPB_CYC,
	parameter int RRD   = RRD_CYC,
	parameter int RP    = RP_CYC
) (
	input wire logic              core_clk,
	input wire logic              rst,
	input wire logic              cs_n,
	input wire logic              cke,
	input wire logic [CA_W-1:0]   ca,
	input wire logic [BANK_W-1:0] ba
);
	// ********
	// link decode and helper state
	// ********
	logic                 cke_r;
	logic [15:0]          cnt_r [5];
	logic [NUM_BANKS-1:0] open_r;
	logic [BANK_W-1:0]    ptr_r;
	logic [BANK_W-1:0]    pb_bank_r;
	logic                 need_r;
	wire live   = !cs_n && cke && cke_r;
	wire is_ref = live && ca[2:0] == 3'b100;
	wire is_pb  = is_ref && !ca[3];
	wire is_ab  = is_ref && ca[3];
	wire is_act = live && ca[1:0] == 2'b10;
	wire is_pre = live && ca[3:0] == 4'hb;
	wire is_rst = live && ca[3:0] == 4'h0;
	wire sr_in  = !cs_n && !cke && cke_r && ca[2:0] == 3'b100;
	wire sr_out = cke && !cke_r;
	wire [4:0] ev = {sr_out, is_pre, is_act, is_pb, is_ab};

	// cycles since each event, saturating so long idle spans never wrap
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst)
			for (int i = 0; i < 5; i++) cnt_r[i] <= 16'hffff;
		else
			for (int i = 0; i < 5; i++)
				if (ev[i])
					cnt_r[i] <= 16'h0001;
				else if (cnt_r[i] != 16'hffff)
					cnt_r[i] <= cnt_r[i] + 16'h0001;
	end

	// open banks, own pointer copy and the refresh owed after an exit
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			cke_r <= 1'b1;
			open_r <= '0;
			ptr_r <= '0;
			pb_bank_r <= '0;
			need_r <= 1'b0;
		end else begin
			cke_r <= cke;
			if (is_act)
				open_r[ba] <= 1'b1;
			if (is_pre || is_rst)
				open_r <= (ca[4] || is_rst) ? '0 : open_r & ~(NUM_BANKS'(1) << ba);
			if (is_pb) begin
				ptr_r <= ptr_r + 3'h1;
				pb_bank_r <= ptr_r;
			end
			if (is_ab || is_rst || sr_out)
				ptr_r <= '0;
			if (sr_out)
				need_r <= 1'b1;
			else if (is_ab || (is_pb && ptr_r == 3'h7))
				need_r <= 1'b0;
		end
	end

	// ********
	// separations and bank state
	// ********
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	a_ab_quiet: assert property ((is_ref || is_act) |-> cnt_r[0] >= RFCAB)
		else $error("command inside all-bank refresh cycle");
	a_pb_spacing: assert property (is_ref |-> cnt_r[1] >= RFCPB)
		else $error("refresh inside per-bank refresh cycle");
	a_act_after_pb: assert property (is_act |->
		cnt_r[2] >= RRD && cnt_r[1] >= ((ba == pb_bank_r) ? RFCPB : RRD))
		else $error("activate too soon");
	a_pb_after_act: assert property (is_pb |-> cnt_r[2] >= RRD)
		else $error("per-bank refresh too soon after activate");
	a_ab_after_pre: assert property (is_ab |-> cnt_r[3] >= RP)
		else $error("all-bank refresh too soon after precharge");
	a_ab_all_idle: assert property (is_ab |-> open_r == '0)
		else $error("all-bank refresh with a bank open");
	a_pb_bank_idle: assert property (is_pb |-> !open_r[ptr_r])
		else $error("per-bank refresh to an open bank");
	a_sr_owed_ref: assert property (sr_in |-> !need_r)
		else $error("self refresh entry without the owed refresh");

	// main scenarios seen on the wire
	c_pb: cover property (is_pb);
	c_ab: cover property (is_ab);
	c_sr: cover property (sr_in);
	c_act_in_pb: cover property (is_act && cnt_r[1] < RFCPB);
endmodule

//--- verification/testbench.sv
// self-checking bench for both ends of the refresh link
`timescale 1ns/1ps
module testbench;
	import lrf_pkg::*;
	localparam int REFI  = 200;
	localparam int LIMIT = 60000;
	logic                     core_clk, rst, run, cke_q, sref_q, act_tk, pre_tk;
	logic                     per_bank_mode, act_req, pre_req, pre_all, rst_req;
	logic                     sr_enter_req, sr_exit_req, act_ready, pre_ready, rst_ready;
	logic                     sr_enter_ready, c_sref, d_sref, ref_pb_seen, ref_ab_seen;
	logic                     access_err, ref_issued;
	logic [BANK_W-1:0]        act_bank, pre_bank, bank_ptr, shadow_ptr, exp_ptr;
	logic signed [CRED_W-1:0] credit, credit_q;
	logic [NUM_BANKS-1:0]     bank_busy, bank_open;
	int                       fail_count, checked, cyc, gap;

	lrf_link_if lrf_link_if_inst ();
	lrf_ctrl #(.REFI(REFI)) lrf_ctrl_inst (.core_clk(core_clk), .rst(rst),
		.link(lrf_link_if_inst.ctrl), .per_bank_mode(per_bank_mode), .act_req(act_req),
		.act_bank(act_bank), .act_ready(act_ready), .pre_req(pre_req), .pre_all(pre_all),
		.pre_bank(pre_bank), .pre_ready(pre_ready), .rst_req(rst_req), .rst_ready(rst_ready),
		.sr_enter_req(sr_enter_req), .sr_enter_ready(sr_enter_ready),
		.sr_exit_req(sr_exit_req), .in_sref(c_sref), .credit(credit),
		.shadow_ptr(shadow_ptr), .ref_issued(ref_issued));
	lrf_dev lrf_dev_inst (.core_clk(core_clk), .rst(rst), .link(lrf_link_if_inst.dev),
		.bank_ptr(bank_ptr), .bank_busy(bank_busy), .bank_open(bank_open), .in_sref(d_sref),
		.ref_pb_seen(ref_pb_seen), .ref_ab_seen(ref_ab_seen), .access_err(access_err));
	lrf_link_assertions lrf_link_assertions_inst (.core_clk(core_clk), .rst(rst),
		.cs_n(lrf_link_if_inst.cs_n), .cke(lrf_link_if_inst.cke),
		.ca(lrf_link_if_inst.ca), .ba(lrf_link_if_inst.ba));
	// a refresh command as the rule spells it, with the clock enable high
	wire ref_on_link = !lrf_link_if_inst.cs_n && lrf_link_if_inst.cke
		&& (lrf_link_if_inst.ca[2:0] == 3'b100);

	// ********
	// clock, comparison and verdict
	// ********
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic print_verdict;
		if (fail_count == 0 && checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// expected device pointer after one cycle of link traffic
	function automatic logic [BANK_W-1:0] next_ptr(logic [BANK_W-1:0] p, logic cs_n,
		logic cke, logic ckq, logic [CA_W-1:0] ca);
		if (cke && !ckq)
			return '0;
		if (cs_n || !cke)
			return p;
		if (ca[2:0] == 3'b100)
			return ca[3] ? '0 : p + 3'h1;
		return (ca[3:0] == 4'h0) ? '0 : p;
	endfunction

	// holds a request until taken; a refusal that never ends counts as a mismatch
	task automatic hold(input int k);
		logic ok;
		ok = 1'b0;
		// ready is looked at on the edge that takes it, before the flops move
		for (int n = 0; n < 5000 && !ok; n++) begin
			@(posedge core_clk);
			ok = (k == 0) ? rst_ready : (k == 1) ? sr_enter_ready : !c_sref;
		end
		@(negedge core_clk);
		check(ok, 1'b1, "request never taken");
	endtask

	// reference pointer and handshake bookkeeping at the sampling edge
	always @(posedge core_clk) begin
		exp_ptr <= rst ? '0 : next_ptr(exp_ptr, lrf_link_if_inst.cs_n,
			lrf_link_if_inst.cke, cke_q, lrf_link_if_inst.ca);
		cke_q <= rst ? 1'b1 : lrf_link_if_inst.cke;
		sref_q <= c_sref;
		credit_q <= credit;
		act_tk <= act_req & act_ready;
		pre_tk <= pre_req & pre_ready;
		cyc++;
		if (cyc == LIMIT) begin
			fail_count++;
			print_verdict();
		end
	end

	// comparisons and random traffic; requests only change once the last one was taken
	always @(negedge core_clk) begin
		if (!rst) begin
			check(bank_ptr, exp_ptr, "device pointer");
			check(access_err, 1'b0, "activate hit refreshing bank");
			check(ref_issued, ref_on_link, "refresh pulse");
			check(d_sref, sref_q, "device self refresh state");
			check(credit >= -8 && credit <= 8, 1'b1, "credit bound");
			check(gap <= 9 * REFI + 1, 1'b1, "refresh gap");
			if (c_sref && sref_q)
				check(credit, credit_q, "credit in self refresh");
			if (ref_ab_seen)
				check(bank_open, 8'h00, "banks after all-bank refresh");
			if (ref_pb_seen) begin
				check(bank_busy[bank_ptr - 3'h1], 1'b1, "refreshing bank busy");
				check(bank_open[bank_ptr - 3'h1], 1'b0, "refreshing bank open");
				check(shadow_ptr, bank_ptr, "shadow pointer");
			end
			gap = (ref_ab_seen || ref_pb_seen || c_sref || per_bank_mode) ? 0 : gap + 1;
		end
		if (!act_req || act_tk) begin
			act_req <= run && ($urandom % 4 == 0);
			act_bank <= BANK_W'($urandom);
		end
		if (!pre_req || pre_tk) begin
			// outside traffic only close what is open, so precharge never starves refresh
			pre_req <= run ? ($urandom % 6 == 0) : (bank_open != '0);
			pre_all <= !run || ($urandom % 2 == 0);
			pre_bank <= BANK_W'($urandom);
		end
	end

	// ********
	// main sequence
	// ********
	initial begin
		fail_count = 0;
		checked = 0;
		cyc = 0;
		gap = 0;
		run = 1'b0;
		per_bank_mode = 1'b0;
		{act_req, pre_req, pre_all, rst_req, sr_enter_req, sr_exit_req} = '0;
		act_bank = BANK_W'($urandom(32'h0ff0));
		pre_bank = '0;
		rst = 1'b1;
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		rst <= 1'b0;
		// all-bank then per-bank, each with a reset command mid-run and two self refreshes
		for (int m = 0; m < 2; m++) begin
			per_bank_mode <= m[0];
			run <= 1'b1;
			repeat (12 * REFI) @(negedge core_clk);
			rst_req <= 1'b1;
			hold(0);
			rst_req <= 1'b0;
			repeat (2 * REFI) @(negedge core_clk);
			run <= 1'b0;
			// second entry straight after exit must wait for the owed refresh
			repeat (2) begin
				sr_enter_req <= 1'b1;
				hold(1);
				sr_enter_req <= 1'b0;
				repeat (3 * REFI) @(negedge core_clk);
				sr_exit_req <= 1'b1;
				hold(2);
				sr_exit_req <= 1'b0;
			end
		end
		print_verdict();
	end
endmodule
